//--- seh_chk.sv
module seh_chk (
    // clock and reset
    input wire        CLK,
    input wire        SYS_RST,
    // request frame
    input wire        REQ_START,
    input wire [5:0]  REQ_NETWORK_FUNCTION_CODE,
    input wire [1:0]  REQ_LUN,
    input wire [7:0]  REQ_CMD,
    input wire [7:0]  REQ_SRC_ADDR,
    input wire        REQ_SYS_IF,
    input wire        REQ_BUSY,
    // response frame
    input wire [5:0]  RSP_NETWORK_FUNCTION_CODE,
    input wire [7:0]  RSP_CMD,
    input wire        RSP_VALID,
    input wire [7:0]  RSP_DATA,
    input wire        RSP_LAST,
    input wire        RSP_READY,
    // event and sensor
    input wire        EVT_VALID,
    input wire [7:0]  EVT_GEN_ID,
    input wire [1:0]  EVT_GEN_LUN,
    input wire [15:0] CFG_SCAN_MAP,
    input wire        SNS_RD_STB,
    input wire        SNS_SCAN,
    input wire [7:0]  SNS_NUM
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    logic take;
    logic bad_cmd;
    logic unsup_reg;
    assign take = REQ_START && !REQ_BUSY;
    assign bad_cmd = REQ_NETWORK_FUNCTION_CODE != 6'h04 || !(REQ_CMD inside {8'h02, 8'h20, 8'h21, 8'h22, 8'h2D});
    // remembers that the frame in flight is unsupported
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST)
            unsup_reg <= 1'h0;
        else if (take)
            unsup_reg <= bad_cmd;
        else if (RSP_VALID && RSP_READY)
            unsup_reg <= 1'h0;
    end
    rsp_network_function_code_a: assert property (take |=> RSP_NETWORK_FUNCTION_CODE == ($past(REQ_NETWORK_FUNCTION_CODE) | 6'h01))
        else $error("response function code not request plus one");
    rsp_cmd_a: assert property (take |=> RSP_CMD == $past(REQ_CMD))
        else $error("response command byte not repeated");
    busy_rise_a: assert property (take |=> REQ_BUSY)
        else $error("busy not raised after frame start");
    rsp_hold_a: assert property (RSP_VALID && !RSP_READY |=>
        RSP_VALID && $stable(RSP_DATA) && $stable(RSP_LAST))
        else $error("response byte changed before taken");
    last_end_a: assert property (RSP_VALID && RSP_READY && RSP_LAST |=> !RSP_VALID)
        else $error("response continues after last byte");
    bad_cmd_a: assert property (RSP_VALID && unsup_reg |-> RSP_DATA == 8'hC1 && RSP_LAST)
        else $error("unsupported request not answered by error code alone");
    evt_gen_a: assert property (EVT_VALID && !REQ_SYS_IF |->
        EVT_GEN_ID == REQ_SRC_ADDR && EVT_GEN_LUN == REQ_LUN)
        else $error("event generator identity wrong");
    evt_pulse_a: assert property (EVT_VALID |=> !EVT_VALID)
        else $error("event strobe longer than one cycle");
    scan_sel_a: assert property (SNS_RD_STB |-> SNS_SCAN == CFG_SCAN_MAP[SNS_NUM[3:0]])
        else $error("sensor scan choice wrong");
    cover property (EVT_VALID);
    cover property (SNS_RD_STB && SNS_SCAN);
    cover property (RSP_VALID && RSP_DATA == 8'h80 && RSP_LAST);
endmodule

bind seh_cmd_handler seh_chk u_chk (.CLK, .SYS_RST, .REQ_START, .REQ_NETWORK_FUNCTION_CODE, .REQ_LUN, .REQ_CMD, .REQ_SRC_ADDR,
    .REQ_SYS_IF, .REQ_BUSY, .RSP_NETWORK_FUNCTION_CODE, .RSP_CMD, .RSP_VALID, .RSP_DATA, .RSP_LAST, .RSP_READY, .EVT_VALID,
    .EVT_GEN_ID, .EVT_GEN_LUN, .CFG_SCAN_MAP, .SNS_RD_STB, .SNS_SCAN, .SNS_NUM);

//--- seh_cmd_handler.v
// How it works
// RULE1: platform event has seven bytes; generator id from sender address and unit; code takes eight with id from byte 1, unit 0, when REQ_SYS_IF
// RULE2: platform event request uses function 04h command 02h, answer 05h
// RULE3: sensor data record info request uses function 04h command 20h
// RULE4: responses use function 05h, repeat command byte, then data bytes
// RULE5: operation bit 0 set returns total sensor data record count
// RULE6: operation absent or bit 0 clear returns sensor count of addressed unit
// RULE7: flags byte: bit 7 dynamic, 6:4 zero, 3:0 units having sensors
// RULE8: bytes 4 to 7 carry the population change indicator
// RULE9: record read supported, mandatory when population is dynamic
// RULE10: record read 04h/21h: reservation, record id, offset, count
// RULE11: count FFh returns the whole record from the offset
// RULE12: record changed under the reservation during multi-part read answers 80h
// RULE13: answer: completion, next record id low/high, then record bytes
// RULE14: reservation 04h/22h, no data; answer completion and 16-bit id low first
// RULE15: sensor reading 04h/2Dh carries one sensor number byte
// RULE16: reading comes from stored value or fresh scan, by sensor type; code picks by the CFG_SCAN_MAP bit at sensor number bits 3:0
// RULE17: unsupported function or command answered with error completion only; code serves function 05h requests like 04h
`include "seh_regs.vh"
module seh_cmd_handler (
    // clock and reset
    input  wire        CLK,
    input  wire        SYS_RST,
    // request frame
    input  wire        REQ_START,
    input  wire [5:0]  REQ_NETWORK_FUNCTION_CODE,
    input  wire [1:0]  REQ_LUN,
    input  wire [7:0]  REQ_CMD,
    input  wire [7:0]  REQ_SRC_ADDR,
    input  wire        REQ_SYS_IF,
    input  wire        REQ_VALID,
    input  wire [7:0]  REQ_DATA,
    input  wire        REQ_END,
    output reg         REQ_BUSY,
    // response frame
    output reg  [5:0]  RSP_NETWORK_FUNCTION_CODE,
    output reg  [1:0]  RSP_LUN,
    output reg  [7:0]  RSP_CMD,
    output reg         RSP_VALID,
    output reg  [7:0]  RSP_DATA,
    output reg         RSP_LAST,
    input  wire        RSP_READY,
    // configuration
    input  wire        CFG_DYNAMIC,
    input  wire [3:0]  CFG_LUN_HAS,
    input  wire [31:0] CFG_SENSOR_CNT,
    input  wire [7:0]  CFG_RECORD_CNT,
    input  wire [31:0] CFG_CHANGE_IND,
    input  wire [15:0] CFG_SCAN_MAP,
    input  wire        RECORD_CHANGED,
    // event out
    output reg         EVT_VALID,
    output reg  [7:0]  EVT_GEN_ID,
    output reg  [1:0]  EVT_GEN_LUN,
    output reg  [7:0]  EVT_REV,
    output reg  [7:0]  EVT_SENSOR_TYPE,
    output reg  [7:0]  EVT_SENSOR_NUM,
    output reg  [7:0]  EVT_DIR_TYPE,
    output reg  [23:0] EVT_DATA,
    // record store
    output reg         REC_RD_STB,
    output reg  [15:0] REC_ID,
    output reg  [7:0]  REC_IDX,
    input  wire        REC_RD_ACK,
    input  wire [7:0]  REC_RD_DATA,
    input  wire [7:0]  REC_LEN,
    input  wire [15:0] REC_NEXT_ID,
    // sensor reading
    output reg         SNS_RD_STB,
    output reg         SNS_SCAN,
    output reg  [7:0]  SNS_NUM,
    input  wire        SNS_ACK,
    input  wire [23:0] SNS_DATA
);

    localparam [2:0] ST_IDLE    = 3'h0;
    localparam [2:0] ST_COLLECT = 3'h1;
    localparam [2:0] ST_EXEC    = 3'h2;
    localparam [2:0] ST_SEND    = 3'h3;
    localparam [2:0] ST_REC_REQ = 3'h4;
    localparam [2:0] ST_REC_OUT = 3'h5;
    localparam [2:0] ST_SNS     = 3'h6;
    localparam [2:0] ST_DRAIN   = 3'h7;

    reg  [2:0]  state_reg;
    reg  [7:0]  req_b [0:7];
    reg  [3:0]  req_len_reg;
    reg  [7:0]  buf_b [0:7];
    reg  [3:0]  rsp_len_reg;
    reg  [3:0]  rsp_idx_reg;
    reg         rec_tail_reg;
    reg         rec_hdr_reg;
    reg  [7:0]  rec_rem_reg;
    reg  [7:0]  byte_reg;
    reg         grant_reg;
    wire [15:0] rsv_id;
    wire        rsv_live;
    wire [3:0]  evt_len;
    wire [3:0]  evt_base;
    wire [7:0]  rec_avail;
    integer     i;

    assign evt_len   = REQ_SYS_IF ? `SEH_EVT_LEN_SYS : `SEH_EVT_LEN_IPMB;
    assign evt_base  = REQ_SYS_IF ? 4'h1 : 4'h0;
    assign rec_avail = REC_LEN - REC_IDX;

    function [7:0] lun_count;
        input [31:0] cnt;
        input [1:0]  logical_unit_number;
        begin
            lun_count = cnt[logical_unit_number*8 +: 8];
        end
    endfunction

    seh_rsv u_rsv (
        .clk          (CLK),
        .rst          (SYS_RST),
        .grant        (grant_reg),
        .changed      (RECORD_CHANGED),
        .rsv_id_reg   (rsv_id),
        .rsv_live_reg (rsv_live)
    );

    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg     <= ST_IDLE;
            req_len_reg   <= 4'h0;
            rsp_len_reg   <= 4'h0;
            rsp_idx_reg   <= 4'h0;
            rec_tail_reg  <= 1'b0;
            rec_hdr_reg   <= 1'b0;
            rec_rem_reg   <= 8'h00;
            byte_reg      <= 8'h00;
            grant_reg     <= 1'b0;
            REQ_BUSY      <= 1'b0;
            RSP_NETWORK_FUNCTION_CODE     <= 6'h00;
            RSP_LUN       <= 2'h0;
            RSP_CMD       <= 8'h00;
            RSP_VALID     <= 1'b0;
            RSP_DATA      <= 8'h00;
            RSP_LAST      <= 1'b0;
            EVT_VALID     <= 1'b0;
            EVT_GEN_ID    <= 8'h00;
            EVT_GEN_LUN   <= 2'h0;
            EVT_REV       <= 8'h00;
            EVT_SENSOR_TYPE <= 8'h00;
            EVT_SENSOR_NUM  <= 8'h00;
            EVT_DIR_TYPE  <= 8'h00;
            EVT_DATA      <= 24'h000000;
            REC_RD_STB    <= 1'b0;
            REC_ID        <= 16'h0000;
            REC_IDX       <= 8'h00;
            SNS_RD_STB    <= 1'b0;
            SNS_SCAN      <= 1'b0;
            SNS_NUM       <= 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                req_b[i] <= 8'h00;
                buf_b[i] <= 8'h00;
            end
        end else begin
            EVT_VALID  <= 1'b0;
            REC_RD_STB <= 1'b0;
            SNS_RD_STB <= 1'b0;
            grant_reg  <= 1'b0;
            if (RSP_VALID && RSP_READY) begin
                RSP_VALID <= 1'b0;
                RSP_LAST  <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (REQ_START) begin
                        RSP_NETWORK_FUNCTION_CODE   <= REQ_NETWORK_FUNCTION_CODE | 6'h01; // RULE4
                        RSP_LUN     <= REQ_LUN;
                        RSP_CMD     <= REQ_CMD; // RULE4
                        req_len_reg <= 4'h0;
                        REQ_BUSY    <= 1'b1;
                        state_reg   <= ST_COLLECT;
                    end
                end
                ST_COLLECT: begin
                    if (REQ_VALID) begin
                        if (req_len_reg < 4'h8)
                            req_b[req_len_reg[2:0]] <= REQ_DATA;
                        if (req_len_reg != 4'hF)
                            req_len_reg <= req_len_reg + 4'h1;
                    end
                    if (REQ_END)
                        state_reg <= ST_EXEC;
                end
                ST_EXEC: begin
                    rsp_idx_reg  <= 4'h0;
                    rec_tail_reg <= 1'b0;
                    buf_b[0]     <= `SEH_CC_OK;
                    rsp_len_reg  <= 4'h1;
                    state_reg    <= ST_SEND;
                    if (RSP_NETWORK_FUNCTION_CODE != `SEH_NETWORK_FUNCTION_CODE_RSP) begin
                        buf_b[0] <= `SEH_CC_BAD_CMD; // RULE17
                    end else begin
                        case (RSP_CMD)
                            `SEH_CMD_PLAT_EVT: begin // RULE2
                                if (req_len_reg != evt_len) begin
                                    buf_b[0] <= `SEH_CC_BAD_LEN;
                                end else begin
                                    // RULE1
                                    EVT_VALID       <= 1'b1;
                                    EVT_GEN_ID      <= REQ_SYS_IF ? req_b[0] : REQ_SRC_ADDR;
                                    EVT_GEN_LUN     <= REQ_SYS_IF ? 2'h0 : REQ_LUN;
                                    EVT_REV         <= req_b[evt_base[2:0]];
                                    EVT_SENSOR_TYPE <= req_b[evt_base[2:0] + 3'h1];
                                    EVT_SENSOR_NUM  <= req_b[evt_base[2:0] + 3'h2];
                                    EVT_DIR_TYPE    <= req_b[evt_base[2:0] + 3'h3];
                                    EVT_DATA        <= {req_b[evt_base[2:0] + 3'h6],
                                                        req_b[evt_base[2:0] + 3'h5],
                                                        req_b[evt_base[2:0] + 3'h4]};
                                end
                            end
                            `SEH_CMD_SDR_INFO: begin // RULE3
                                if (req_len_reg != 4'h0 && req_b[0][`SEH_OP_COUNT_BIT])
                                    buf_b[1] <= CFG_RECORD_CNT; // RULE5
                                else
                                    buf_b[1] <= lun_count(CFG_SENSOR_CNT, RSP_LUN); // RULE6
                                buf_b[2] <= {CFG_DYNAMIC, 3'h0, CFG_LUN_HAS}; // RULE7
                                buf_b[3] <= CFG_CHANGE_IND[7:0]; // RULE8
                                buf_b[4] <= CFG_CHANGE_IND[15:8];
                                buf_b[5] <= CFG_CHANGE_IND[23:16];
                                buf_b[6] <= CFG_CHANGE_IND[31:24];
                                rsp_len_reg <= `SEH_INFO_RSP_LEN;
                            end
                            `SEH_CMD_SDR_GET: begin // RULE9 RULE10
                                if (req_len_reg < `SEH_SDR_GET_LEN) begin
                                    buf_b[0] <= `SEH_CC_BAD_LEN;
                                end else if (req_b[4] != 8'h00 &&
                                             (!rsv_live || {req_b[1], req_b[0]} != rsv_id)) begin
                                    buf_b[0] <= `SEH_CC_REC_CHANGED; // RULE12
                                end else begin
                                    REC_ID      <= {req_b[3], req_b[2]};
                                    REC_IDX     <= req_b[4];
                                    REC_RD_STB  <= 1'b1;
                                    rec_hdr_reg <= 1'b1;
                                    state_reg   <= ST_REC_REQ;
                                end
                            end
                            `SEH_CMD_SDR_RSV: begin
                                grant_reg <= 1'b1; // RULE14
                                state_reg <= ST_DRAIN;
                            end
                            `SEH_CMD_SNS_READ: begin // RULE15
                                if (req_len_reg != `SEH_SNS_READ_LEN) begin
                                    buf_b[0] <= `SEH_CC_BAD_LEN;
                                end else begin
                                    SNS_NUM    <= req_b[0];
                                    SNS_SCAN   <= CFG_SCAN_MAP[req_b[0][3:0]]; // RULE16
                                    SNS_RD_STB <= 1'b1;
                                    state_reg  <= ST_SNS;
                                end
                            end
                            default: buf_b[0] <= `SEH_CC_BAD_CMD; // RULE17
                        endcase
                    end
                end
                ST_SEND: begin
                    if (!RSP_VALID || RSP_READY) begin
                        if (rsp_idx_reg < rsp_len_reg) begin
                            RSP_VALID   <= 1'b1;
                            RSP_DATA    <= buf_b[rsp_idx_reg[2:0]];
                            RSP_LAST    <= (rsp_idx_reg == rsp_len_reg - 4'h1) && !rec_tail_reg;
                            rsp_idx_reg <= rsp_idx_reg + 4'h1;
                        end else if (rec_tail_reg) begin
                            REC_RD_STB <= 1'b1;
                            state_reg  <= ST_REC_REQ;
                        end else begin
                            REQ_BUSY  <= 1'b0;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_REC_REQ: begin
                    if (REC_RD_ACK) begin
                        if (rec_hdr_reg) begin
                            rec_hdr_reg <= 1'b0;
                            buf_b[1]    <= REC_NEXT_ID[7:0]; // RULE13
                            buf_b[2]    <= REC_NEXT_ID[15:8];
                            rsp_len_reg <= 4'h3;
                            state_reg   <= ST_SEND;
                            if (REC_IDX >= REC_LEN) begin
                                buf_b[0]    <= `SEH_CC_RANGE;
                                rsp_len_reg <= 4'h1;
                            end else if (req_b[5] == `SEH_READ_ALL || req_b[5] > rec_avail) begin
                                rec_rem_reg  <= rec_avail; // RULE11
                                rec_tail_reg <= 1'b1;
                            end else begin
                                rec_rem_reg  <= req_b[5];
                                rec_tail_reg <= (req_b[5] != 8'h00);
                            end
                        end else begin
                            byte_reg      <= REC_RD_DATA;
                            state_reg     <= ST_REC_OUT;
                        end
                    end
                end
                ST_REC_OUT: begin
                    if (!RSP_VALID || RSP_READY) begin
                        RSP_VALID     <= 1'b1;
                        RSP_DATA      <= byte_reg; // RULE13
                        RSP_LAST      <= (rec_rem_reg == 8'h01);
                        rec_rem_reg   <= rec_rem_reg - 8'h01;
                        REC_IDX       <= REC_IDX + 8'h01;
                        if (rec_rem_reg == 8'h01) begin
                            rec_tail_reg <= 1'b0;
                            state_reg    <= ST_SEND;
                        end else begin
                            REC_RD_STB <= 1'b1;
                            state_reg  <= ST_REC_REQ;
                        end
                    end
                end
                ST_SNS: begin
                    if (SNS_ACK) begin
                        buf_b[1]    <= SNS_DATA[7:0];
                        buf_b[2]    <= SNS_DATA[15:8];
                        buf_b[3]    <= SNS_DATA[23:16];
                        rsp_len_reg <= 4'h4;
                        state_reg   <= ST_SEND;
                    end
                end
                ST_DRAIN: begin
                    // counter updates on the edge after the grant pulse; wait for it
                    if (!grant_reg) begin
                        buf_b[1]    <= rsv_id[7:0]; // RULE14
                        buf_b[2]    <= rsv_id[15:8];
                        rsp_len_reg <= 4'h3;
                        state_reg   <= ST_SEND;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule

//--- seh_regs.vh
`ifndef SEH_REGS_VH
`define SEH_REGS_VH

// network function codes
`define SEH_NETWORK_FUNCTION_CODE_REQ      6'h04
`define SEH_NETWORK_FUNCTION_CODE_RSP      6'h05

// command bytes
`define SEH_CMD_PLAT_EVT   8'h02
`define SEH_CMD_SDR_INFO   8'h20
`define SEH_CMD_SDR_GET    8'h21
`define SEH_CMD_SDR_RSV    8'h22
`define SEH_CMD_SNS_READ   8'h2D

// completion codes
`define SEH_CC_OK          8'h00
`define SEH_CC_REC_CHANGED 8'h80
`define SEH_CC_BAD_CMD     8'hC1
`define SEH_CC_BAD_LEN     8'hC7
`define SEH_CC_RANGE       8'hC9

// request and response field values and lengths
`define SEH_READ_ALL       8'hFF
`define SEH_EVT_LEN_IPMB   4'h7
`define SEH_EVT_LEN_SYS    4'h8
`define SEH_SDR_GET_LEN    4'h6
`define SEH_SNS_READ_LEN   4'h1
`define SEH_INFO_RSP_LEN   4'h7
`define SEH_OP_COUNT_BIT   0
`define SEH_FLAG_DYN_BIT   7

`endif

//--- seh_rsv.v
module seh_rsv (
    input  wire        clk,
    input  wire        rst,
    input  wire        grant,
    input  wire        changed,
    output reg  [15:0] rsv_id_reg,
    output reg         rsv_live_reg
);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rsv_id_reg   <= 16'h0000;
            rsv_live_reg <= 1'b0;
        end else if (grant) begin
            // new grant wins over a change in the same cycle; id 0 never handed out
            rsv_id_reg   <= (rsv_id_reg == 16'hFFFF) ? 16'h0001 : rsv_id_reg + 16'h0001; // RULE14
            rsv_live_reg <= 1'b1;
        end else if (changed) begin
            rsv_live_reg <= 1'b0; // RULE12
        end
    end

endmodule

//--- seh_store.sv
module seh_store (
    // clock and reset
    input  logic        clk,
    input  logic        rst,
    // answer pace
    input  logic        slow,
    // record store
    input  logic        rec_rd_stb,
    input  logic [15:0] rec_id,
    input  logic [7:0]  rec_idx,
    output logic        rec_rd_ack,
    output logic [7:0]  rec_rd_data,
    output logic [7:0]  rec_len,
    output logic [15:0] rec_next_id,
    // sensor
    input  logic        sns_rd_stb,
    input  logic        sns_scan,
    input  logic [7:0]  sns_num,
    output logic        sns_ack,
    output logic [23:0] sns_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] rec_wait;
    logic [2:0] sns_wait;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {rec_wait, sns_wait, rec_rd_ack, sns_ack} <= 8'h00;
            {rec_rd_data, rec_len, rec_next_id, sns_data} <= 56'h0;
        end else begin
            rec_rd_ack <= 1'h0;
            sns_ack <= 1'h0;
            // data not qualified by an ack keeps changing
            rec_rd_data <= ~rec_rd_data;
            sns_data <= ~sns_data;
            rec_wait <= rec_rd_stb ? (slow ? 3'h4 : 3'h1) : (rec_wait != 3'h0 ? rec_wait - 3'h1 : 3'h0);
            sns_wait <= sns_rd_stb ? (slow ? 3'h5 : 3'h1) : (sns_wait != 3'h0 ? sns_wait - 3'h1 : 3'h0);
            if (rec_wait == 3'h1) begin
                rec_rd_ack <= 1'h1;
                rec_rd_data <= {rec_id[3:0], rec_idx[3:0]};
                rec_len <= 8'h05;
                rec_next_id <= rec_id + 16'h0001;
            end
            if (sns_wait == 3'h1) begin
                sns_ack <= 1'h1;
                sns_data <= {sns_num, 7'h00, sns_scan, 8'hC3};
            end
        end
    end
endmodule

//--- test_seh_cmd_handler.sv
module test_seh_cmd_handler;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 1'h0, SYS_RST = 1'h1, REQ_START = 1'h0, REQ_SYS_IF = 1'h0, REQ_VALID = 1'h0, REQ_END = 1'h0;
    logic        RSP_READY = 1'h0, CFG_DYNAMIC = 1'h1, RECORD_CHANGED = 1'h0, stall = 1'h0, slow = 1'h0;
    logic        evt_seen = 1'h0;
    logic [5:0]  REQ_NETWORK_FUNCTION_CODE = 6'h04;
    logic [1:0]  REQ_LUN = 2'h0;
    logic [7:0]  REQ_CMD = 8'h00, REQ_SRC_ADDR = 8'h82, REQ_DATA = 8'h00, CFG_RECORD_CNT = 8'h0C;
    logic [3:0]  CFG_LUN_HAS = 4'h5;
    logic [31:0] CFG_SENSOR_CNT = 32'h04030201, CFG_CHANGE_IND = 32'h44332211;
    logic [15:0] CFG_SCAN_MAP = 16'h0008;
    wire         REQ_BUSY, RSP_VALID, RSP_LAST, EVT_VALID, REC_RD_STB, REC_RD_ACK, SNS_RD_STB, SNS_SCAN, SNS_ACK;
    wire  [5:0]  RSP_NETWORK_FUNCTION_CODE;
    wire  [1:0]  RSP_LUN, EVT_GEN_LUN;
    wire  [7:0]  RSP_CMD, RSP_DATA, EVT_GEN_ID, EVT_REV, EVT_SENSOR_TYPE, EVT_SENSOR_NUM, EVT_DIR_TYPE;
    wire  [7:0]  REC_IDX, REC_RD_DATA, REC_LEN, SNS_NUM;
    wire  [15:0] REC_ID, REC_NEXT_ID;
    wire  [23:0] EVT_DATA, SNS_DATA;
    int          num_errors = 0, checked = 0, rn;
    logic [7:0]  rb [0:15];

    seh_cmd_handler DUT (.CLK, .SYS_RST, .REQ_START, .REQ_NETWORK_FUNCTION_CODE, .REQ_LUN, .REQ_CMD, .REQ_SRC_ADDR, .REQ_SYS_IF,
        .REQ_VALID, .REQ_DATA, .REQ_END, .REQ_BUSY, .RSP_NETWORK_FUNCTION_CODE, .RSP_LUN, .RSP_CMD, .RSP_VALID, .RSP_DATA,
        .RSP_LAST, .RSP_READY, .CFG_DYNAMIC, .CFG_LUN_HAS, .CFG_SENSOR_CNT, .CFG_RECORD_CNT, .CFG_CHANGE_IND,
        .CFG_SCAN_MAP, .RECORD_CHANGED, .EVT_VALID, .EVT_GEN_ID, .EVT_GEN_LUN, .EVT_REV, .EVT_SENSOR_TYPE,
        .EVT_SENSOR_NUM, .EVT_DIR_TYPE, .EVT_DATA, .REC_RD_STB, .REC_ID, .REC_IDX, .REC_RD_ACK, .REC_RD_DATA,
        .REC_LEN, .REC_NEXT_ID, .SNS_RD_STB, .SNS_SCAN, .SNS_NUM, .SNS_ACK, .SNS_DATA);
    seh_store u_store (.clk(CLK), .rst(SYS_RST), .slow, .rec_rd_stb(REC_RD_STB), .rec_id(REC_ID),
        .rec_idx(REC_IDX), .rec_rd_ack(REC_RD_ACK), .rec_rd_data(REC_RD_DATA), .rec_len(REC_LEN),
        .rec_next_id(REC_NEXT_ID), .sns_rd_stb(SNS_RD_STB), .sns_scan(SNS_SCAN), .sns_num(SNS_NUM),
        .sns_ack(SNS_ACK), .sns_data(SNS_DATA));

    initial begin
        forever #2 CLK = ~CLK;
    end
    always @(negedge CLK) begin
        if (EVT_VALID === 1'h1)
            evt_seen = 1'h1;
    end

    task automatic chk(input logic [63:0] g, input logic [63:0] x);
        checked++;
        if (g !== x) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    // one request frame, then its whole response, then the byte compare
    task automatic run(input logic [5:0] nf, input logic [7:0] cmd, input int n, input logic [63:0] d,
                       input int en, input logic [63:0] e);
        logic done;
        done = 1'h0;
        rn = 0;
        foreach (rb[i]) rb[i] = 8'hXX;
        @(negedge CLK);
        RSP_READY = 1'h0;
        REQ_NETWORK_FUNCTION_CODE = nf;
        REQ_CMD = cmd;
        REQ_START = 1'h1;
        @(negedge CLK);
        REQ_START = 1'h0;
        for (int i = 0; i < n; i++) begin
            REQ_VALID = 1'h1;
            REQ_DATA = d[8*i+:8];
            REQ_END = (i == n - 1);
            @(negedge CLK);
        end
        REQ_VALID = 1'h0;
        REQ_END = (n == 0);
        @(negedge CLK);
        REQ_END = 1'h0;
        for (int k = 0; k < 300 && !done; k++) begin
            @(negedge CLK);
            RSP_READY = stall ? ~RSP_READY : 1'h1;
            // byte standing now is taken at the coming rising edge
            if (RSP_VALID === 1'h1 && RSP_READY) begin
                rb[rn] = RSP_DATA;
                rn++;
                done = RSP_LAST;
            end
        end
        for (int k = 0; k < 20 && REQ_BUSY !== 1'h0; k++) @(negedge CLK);
        chk({RSP_NETWORK_FUNCTION_CODE, RSP_LUN, RSP_CMD, REQ_BUSY}, {nf | 6'h01, REQ_LUN, cmd, 1'h0});
        chk(rn, en);
        for (int i = 0; i < en; i++) chk(rb[i], e[8*i+:8]);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #(30000 * 4);
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (6) @(negedge CLK);
        SYS_RST = 1'h0;
        run(6'h04, 8'h22, 0, 0, 3, 24'h000100);
        run(6'h04, 8'h22, 0, 0, 3, 24'h000200);
        run(6'h04, 8'h20, 1, 1, 7, 56'h44332211_850C00);
        CFG_DYNAMIC = 1'h0;
        REQ_LUN = 2'h2;
        run(6'h04, 8'h20, 1, 0, 7, 56'h44332211_050300);
        REQ_LUN = 2'h1;
        run(6'h04, 8'h20, 0, 0, 7, 56'h44332211_050200);
        run(6'h04, 8'h21, 6, 48'hFF0000070002, 8, 64'h74737271_70000800);
        stall = 1'h1;
        slow = 1'h1;
        run(6'h04, 8'h21, 6, 48'h020200070002, 5, 40'h73_72000800);
        run(6'h04, 8'h21, 6, 48'h010500070002, 1, 8'hC9);
        @(negedge CLK);
        RECORD_CHANGED = 1'h1;
        @(negedge CLK);
        RECORD_CHANGED = 1'h0;
        run(6'h04, 8'h21, 6, 48'h010100070002, 1, 8'h80);
        run(6'h04, 8'h2D, 1, 8'h13, 4, 32'h1301C300);
        stall = 1'h0;
        run(6'h04, 8'h2D, 1, 8'h14, 4, 32'h1400C300);
        run(6'h04, 8'h2D, 0, 0, 1, 8'hC7);
        run(6'h04, 8'h02, 7, 56'hC3B2A16F220104, 1, 8'h00);
        chk(evt_seen, 1'h1);
        chk({EVT_GEN_ID, 6'h00, EVT_GEN_LUN}, 16'h8201);
        chk({EVT_REV, EVT_SENSOR_TYPE, EVT_SENSOR_NUM, EVT_DIR_TYPE}, 32'h0401226F);
        chk(EVT_DATA, 24'hC3B2A1);
        REQ_SYS_IF = 1'h1;
        run(6'h04, 8'h02, 8, 64'hC3B2A16F22010455, 1, 8'h00);
        chk({EVT_GEN_ID, 6'h00, EVT_GEN_LUN}, 16'h5500);
        chk({EVT_REV, EVT_SENSOR_TYPE, EVT_SENSOR_NUM, EVT_DIR_TYPE}, 32'h0401226F);
        run(6'h04, 8'h02, 7, 56'hC3B2A16F220104, 1, 8'hC7);
        REQ_SYS_IF = 1'h0;
        run(6'h04, 8'h02, 6, 48'hB2A16F220104, 1, 8'hC7);
        run(6'h04, 8'h2E, 0, 0, 1, 8'hC1);
        run(6'h06, 8'h01, 0, 0, 1, 8'hC1);
        complete_run();
    end
endmodule
